// File: hw/fcs_host.sv
`timescale 1ns/1ps
// apb-controlled host that drives flash command sequences on the parallel bus
`include "fcs_consts.svh"
// Function
// - extra 30h sector writes must follow within 80 us; the host still sends a late one and only flags it in status bit 2.
// - F0 anywhere returns to read array; needed after id or error.
// - AA, 55, 20 enters bypass; then A0 plus data programs.
// - in bypass, 90h then 00h leaves to read array.
// - each command cycle has the matching sector select high.
// - commands are byte writes to even address; program word even.
// - selects and write strobe stay deasserted during power-up.
// - no id or protection commands to the array holding running code; the host does not block them.
module fcs_host
    import fcs_pkg::*;
#(
    parameter int EXT_WIN_CYC = `FCS_EXT_WIN_CYC
) (
    // clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        rst_n_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // device pins
    input  wire logic        power_good_in,
    input  wire logic [15:0] dev_data_in,
    output logic             dev_wr_n_out,
    output logic             dev_rd_n_out,
    output logic [7:0]       main_sector_select_out,
    output logic [3:0]       secondary_sector_select_out,
    output logic [19:0]      dev_addr_out,
    output logic [15:0]      dev_data_out,
    output logic             dev_data_oe_n_out
);
    typedef struct packed {
        fcs_state_t  st;
        fcs_op_t     op;
        logic [2:0]  step;
        logic [19:0] addr;
        logic [15:0] wdata;
        logic [11:0] sel;
        logic [15:0] rdata;
        logic [1:0]  cnt;
        logic [31:0] win;
        logic        ext_late;
        fcs_pins_t   pins;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } fcs_host_state_t;

    fcs_host_state_t s_q, s_d;
    fcs_cyc_t        cyc;
    logic [2:0]      len;
    logic            apb_acc;
    logic            sel_any;

    fcs_seq_rom u_rom (
        .op_in   (s_q.op),
        .step_in (s_q.step),
        .addr_in (s_q.addr),
        .data_in (s_q.wdata),
        .cyc_out (cyc),
        .len_out (len)
    );

    assign apb_acc = psel_in && penable_in && !s_q.pready;
    assign sel_any = |s_q.sel;

    always_comb begin
        s_d = s_q;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        if (s_q.win != 32'h0)
            s_d.win = s_q.win - 32'd1;
        // apb access, one wait state
        if (apb_acc) begin
            s_d.pready = 1'b1;
            s_d.prdata = 32'h0;
            unique case (paddr_in)
                `FCS_REG_CTRL: begin
                    // no guard here: software keeps id/prot off the array it runs
                    if (pwrite_in && pwdata_in[`FCS_CTRL_GO_BIT] && s_q.st == FCS_ST_IDLE
                        && power_good_in && sel_any) begin
                        s_d.op   = fcs_op_t'(pwdata_in[`FCS_CTRL_OP_LSB +: `FCS_CTRL_OP_W]);
                        s_d.step = 3'd0;
                        s_d.st   = FCS_ST_SETUP;
                        // late extension would let the device close the erase window
                        s_d.ext_late = (s_d.op == FCS_OP_SECT_ADD) && (s_q.win == 32'h0);
                    end
                    s_d.prdata[`FCS_CTRL_OP_LSB +: `FCS_CTRL_OP_W] = s_q.op;
                end
                `FCS_REG_ADDR: begin
                    if (pwrite_in) s_d.addr = pwdata_in[19:0];
                    s_d.prdata[19:0] = s_q.addr;
                end
                `FCS_REG_DATA: begin
                    if (pwrite_in) s_d.wdata = pwdata_in[15:0];
                    s_d.prdata[15:0] = s_q.wdata;
                end
                `FCS_REG_SEL: begin
                    if (pwrite_in && s_q.st == FCS_ST_IDLE) s_d.sel = pwdata_in[11:0];
                    s_d.prdata[11:0] = s_q.sel;
                end
                `FCS_REG_STATUS: begin
                    s_d.prdata[`FCS_ST_BUSY_BIT] = (s_q.st != FCS_ST_IDLE);
                    s_d.prdata[`FCS_ST_PWR_BIT]  = power_good_in;
                    s_d.prdata[2] = s_q.ext_late;
                    s_d.prdata[3] = (s_q.win != 32'h0);
                end
                `FCS_REG_RDATA: begin
                    // status byte lives on the lower lane, bits 7:0 of the read data
                    s_d.prdata[15:0] = s_q.rdata;
                end
                default: s_d.pslverr = 1'b1;
            endcase
        end
        // bus cycle engine toward the device
        unique case (s_q.st)
            FCS_ST_IDLE: begin
                s_d.pins.wr_n = 1'b1;
                s_d.pins.rd_n = 1'b1;
                s_d.pins.main_sector_select = 8'h00;
                s_d.pins.secondary_sector_select = 4'h0;
                s_d.pins.doe_n = 1'b1;
            end
            FCS_ST_SETUP: begin
                s_d.pins.addr = cyc.addr;
                s_d.pins.main_sector_select = s_q.sel[7:0];
                s_d.pins.secondary_sector_select = s_q.sel[11:8];
                s_d.pins.dout = cyc.data;
                s_d.pins.doe_n = !cyc.wr;
                s_d.cnt = 2'd0;
                s_d.st = FCS_ST_STROBE;
            end
            FCS_ST_STROBE: begin
                s_d.pins.wr_n = !cyc.wr;
                s_d.pins.rd_n = cyc.wr;
                s_d.cnt = s_q.cnt + 2'd1;
                if (s_q.cnt == 2'(`FCS_STROBE_CYC - 1)) s_d.st = FCS_ST_HOLD;
            end
            FCS_ST_HOLD: begin
                if (!cyc.wr) s_d.rdata = dev_data_in;
                s_d.pins.wr_n = 1'b1;
                s_d.pins.rd_n = 1'b1;
                s_d.st = FCS_ST_NEXT;
            end
            FCS_ST_NEXT: begin
                s_d.pins.main_sector_select = 8'h00;
                s_d.pins.secondary_sector_select = 4'h0;
                s_d.pins.doe_n = 1'b1;
                if (s_q.step + 3'd1 >= len) begin
                    s_d.st = FCS_ST_IDLE;
                    if (s_q.op == FCS_OP_SECT || s_q.op == FCS_OP_SECT_ADD)
                        s_d.win = 32'(EXT_WIN_CYC);
                end else begin
                    s_d.step = s_q.step + 3'd1;
                    s_d.st = FCS_ST_SETUP;
                end
            end
            default: s_d.st = FCS_ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            s_q <= '{st: FCS_ST_IDLE, op: FCS_OP_READ, step: 3'd0, addr: 20'h0,
                     wdata: 16'h0, sel: 12'h000, rdata: 16'h0, cnt: 2'd0, win: 32'h0,
                     ext_late: 1'b0,
                     pins: '{wr_n: 1'b1, rd_n: 1'b1, main_sector_select: 8'h00,
                             secondary_sector_select: 4'h0, addr: 20'h0, dout: 16'h0,
                             doe_n: 1'b1},
                     prdata: 32'h0, pready: 1'b0, pslverr: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata_out = s_q.prdata;
    assign pready_out = s_q.pready;
    assign pslverr_out = s_q.pslverr;
    assign dev_wr_n_out = s_q.pins.wr_n;
    assign dev_rd_n_out = s_q.pins.rd_n;
    assign main_sector_select_out = s_q.pins.main_sector_select;
    assign secondary_sector_select_out = s_q.pins.secondary_sector_select;
    assign dev_addr_out = s_q.pins.addr;
    assign dev_data_out = s_q.pins.dout;
    assign dev_data_oe_n_out = s_q.pins.doe_n;

    property p_sel_idle;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (s_q.st == FCS_ST_IDLE) |=> (s_q.pins.main_sector_select == 8'h00
                                     && s_q.pins.wr_n);
    endproperty
    a_sel_idle: assert property (p_sel_idle) else $error("select high while idle");

    property p_strobe_len;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        $fell(s_q.pins.wr_n) |-> !s_q.pins.wr_n [*2] ##1 s_q.pins.wr_n;
    endproperty
    a_strobe_len: assert property (p_strobe_len) else $error("write strobe width wrong");

    property p_addr_stable;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        !s_q.pins.wr_n |-> $stable(s_q.pins.addr) && $stable(s_q.pins.dout);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("bus moved in strobe");

    property p_wr_sel;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        !s_q.pins.wr_n |-> (|{s_q.pins.main_sector_select,
                              s_q.pins.secondary_sector_select}) && !s_q.pins.doe_n;
    endproperty
    a_wr_sel: assert property (p_wr_sel) else $error("write without select");

    property p_cmd_even;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        $fell(s_q.pins.wr_n) |-> !s_q.pins.addr[0];
    endproperty
    a_cmd_even: assert property (p_cmd_even) else $error("odd write address");

    property p_first_unlock;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        $fell(s_q.pins.wr_n) && s_q.step == 3'd0 && (s_q.op == FCS_OP_PROG
            || s_q.op == FCS_OP_ID) |-> s_q.pins.addr[11:0] == 12'haaa
            && s_q.pins.dout[7:0] == 8'haa;
    endproperty
    a_first_unlock: assert property (p_first_unlock) else $error("bad first unlock");

    property p_win_load;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        s_q.st == FCS_ST_NEXT && s_q.op == FCS_OP_SECT && s_q.step == 3'd5
            |=> s_q.win == 32'(EXT_WIN_CYC);
    endproperty
    a_win_load: assert property (p_win_load) else $error("erase window not armed");

    property p_apb_ans;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        psel_in && penable_in && !pready_out |=> pready_out;
    endproperty
    a_apb_ans: assert property (p_apb_ans) else $error("apb answer late");
endmodule : fcs_host

// File: hw/fcs_consts.svh
// constants for the flash command sequencer host controller
`ifndef FCS_CONSTS_SVH
`define FCS_CONSTS_SVH
// apb register byte offsets
`define FCS_REG_CTRL      12'h000
`define FCS_REG_ADDR      12'h004
`define FCS_REG_DATA      12'h008
`define FCS_REG_SEL       12'h00c
`define FCS_REG_STATUS    12'h010
`define FCS_REG_RDATA     12'h014
// ctrl fields
`define FCS_CTRL_GO_BIT   0
`define FCS_CTRL_OP_LSB   4
`define FCS_CTRL_OP_W     4
// status fields
`define FCS_ST_BUSY_BIT   0
`define FCS_ST_PWR_BIT    1
// command bytes and unlock addresses
`define FCS_UNLOCK_A      12'haaa
`define FCS_UNLOCK_B      12'h554
`define FCS_BYTE_AA       8'haa
`define FCS_BYTE_55       8'h55
`define FCS_CMD_ID        8'h90
`define FCS_CMD_PROG      8'ha0
`define FCS_CMD_ERASE     8'h80
`define FCS_CMD_SECTOR    8'h30
`define FCS_CMD_BULK      8'h10
`define FCS_CMD_SUSPEND   8'hb0
`define FCS_CMD_RESET     8'hf0
`define FCS_CMD_BYPASS    8'h20
`define FCS_CMD_BYP_EXIT  8'h00
`define FCS_OFS_ID        12'h002
`define FCS_OFS_PROT      12'h004
// timing, 50 MHz clock
`define FCS_CLK_MHZ       50
`define FCS_EXT_WIN_US    80
`define FCS_EXT_WIN_CYC   (`FCS_EXT_WIN_US * `FCS_CLK_MHZ)
`define FCS_STROBE_CYC    2
`endif

// File: hw/fcs_pkg.sv
// types for the flash command sequencer host controller
package fcs_pkg;
    typedef enum logic [3:0] {
        FCS_OP_READ = 4'h0, FCS_OP_ID = 4'h1, FCS_OP_PROT = 4'h2, FCS_OP_PROG = 4'h3,
        FCS_OP_SECT = 4'h4, FCS_OP_BULK = 4'h5, FCS_OP_SUSP = 4'h6, FCS_OP_RESUME = 4'h7,
        FCS_OP_RESET = 4'h8, FCS_OP_BYP_ON = 4'h9, FCS_OP_BYP_PROG = 4'ha,
        FCS_OP_BYP_OFF = 4'hb, FCS_OP_SECT_ADD = 4'hc
    } fcs_op_t;
    typedef enum logic [4:0] {
        FCS_ST_IDLE = 5'b00001, FCS_ST_SETUP = 5'b00010, FCS_ST_STROBE = 5'b00100,
        FCS_ST_HOLD = 5'b01000, FCS_ST_NEXT = 5'b10000
    } fcs_state_t;
    // one bus cycle toward the device
    typedef struct packed {
        logic        wr;
        logic [19:0] addr;
        logic [15:0] data;
    } fcs_cyc_t;
    // pins toward the device
    typedef struct packed {
        logic        wr_n;
        logic        rd_n;
        logic [7:0]  main_sector_select;
        logic [3:0]  secondary_sector_select;
        logic [19:0] addr;
        logic [15:0] dout;
        logic        doe_n;
    } fcs_pins_t;
endpackage : fcs_pkg

// File: hw/fcs_seq_rom.sv
`timescale 1ns/1ps
// maps an operation and step number onto one bus cycle
`include "fcs_consts.svh"
module fcs_seq_rom
    import fcs_pkg::*;
(
    // request
    input  wire fcs_op_t     op_in,
    input  wire logic [2:0]  step_in,
    input  wire logic [19:0] addr_in,
    input  wire logic [15:0] data_in,
    // cycle
    output fcs_cyc_t         cyc_out,
    output logic [2:0]       len_out
);
    function automatic fcs_cyc_t wc(input logic [11:0] a, input logic [7:0] d);
        wc = '{wr: 1'b1, addr: {addr_in[19:12], a}, data: {8'h00, d}};
    endfunction : wc
    logic [19:0] even_a;
    assign even_a = {addr_in[19:1], 1'b0};
    always_comb begin
        cyc_out = '{wr: 1'b0, addr: even_a, data: 16'h0000};
        len_out = 3'd1;
        unique case (op_in)
            FCS_OP_READ: len_out = 3'd1;
            FCS_OP_ID, FCS_OP_PROT, FCS_OP_PROG, FCS_OP_BYP_ON, FCS_OP_SECT, FCS_OP_BULK: begin
                len_out = (op_in == FCS_OP_ID || op_in == FCS_OP_PROT || op_in == FCS_OP_PROG)
                          ? 3'd4 : (op_in == FCS_OP_BYP_ON ? 3'd3 : 3'd6);
                case (step_in)
                    3'd0: cyc_out = wc(`FCS_UNLOCK_A, `FCS_BYTE_AA);
                    3'd1: cyc_out = wc(`FCS_UNLOCK_B, `FCS_BYTE_55);
                    3'd2: cyc_out = wc(`FCS_UNLOCK_A,
                            (op_in == FCS_OP_PROG) ? `FCS_CMD_PROG :
                            (op_in == FCS_OP_BYP_ON) ? `FCS_CMD_BYPASS :
                            (op_in == FCS_OP_SECT || op_in == FCS_OP_BULK)
                                ? `FCS_CMD_ERASE : `FCS_CMD_ID);
                    3'd3: begin
                        if (op_in == FCS_OP_ID)
                            cyc_out.addr = {addr_in[19:12], `FCS_OFS_ID};
                        else if (op_in == FCS_OP_PROT)
                            cyc_out.addr = {addr_in[19:12], `FCS_OFS_PROT};
                        else if (op_in == FCS_OP_PROG)
                            cyc_out = '{wr: 1'b1, addr: even_a, data: data_in};
                        else
                            cyc_out = wc(`FCS_UNLOCK_A, `FCS_BYTE_AA);
                    end
                    3'd4: cyc_out = wc(`FCS_UNLOCK_B, `FCS_BYTE_55);
                    default: cyc_out = (op_in == FCS_OP_BULK)
                            ? wc(`FCS_UNLOCK_A, `FCS_CMD_BULK)
                            : '{wr: 1'b1, addr: even_a, data: {8'h00, `FCS_CMD_SECTOR}};
                endcase
            end
            FCS_OP_SECT_ADD: cyc_out = '{wr: 1'b1, addr: even_a,
                                         data: {8'h00, `FCS_CMD_SECTOR}};
            FCS_OP_SUSP: cyc_out = '{wr: 1'b1, addr: even_a,
                                     data: {8'h00, `FCS_CMD_SUSPEND}};
            FCS_OP_RESUME: cyc_out = '{wr: 1'b1, addr: even_a,
                                       data: {8'h00, `FCS_CMD_SECTOR}};
            FCS_OP_RESET: cyc_out = '{wr: 1'b1, addr: even_a,
                                      data: {8'h00, `FCS_CMD_RESET}};
            FCS_OP_BYP_PROG: begin
                len_out = 3'd2;
                cyc_out = (step_in == 3'd0)
                    ? '{wr: 1'b1, addr: even_a, data: {8'h00, `FCS_CMD_PROG}}
                    : '{wr: 1'b1, addr: even_a, data: data_in};
            end
            FCS_OP_BYP_OFF: begin
                len_out = 3'd2;
                cyc_out = '{wr: 1'b1, addr: even_a,
                            data: {8'h00, (step_in == 3'd0) ? `FCS_CMD_ID
                                                            : `FCS_CMD_BYP_EXIT}};
            end
            default: len_out = 3'd1;
        endcase
    end
endmodule : fcs_seq_rom

// File: sim/fcs_dev_model.sv
// behavioural flash device answering the host's parallel bus
`timescale 1ns/1ps
module fcs_dev_model #(
    parameter logic [7:0]  ID_CODE   = 8'h5c, // arbitrary identifier value
    parameter logic [11:0] PROT_MASK = 12'h024,
    parameter int          ERASE_CYC = 300
) (
    // clock
    input  wire logic        clk_in,
    // host pins
    input  wire logic        wr_n_in,
    input  wire logic        rd_n_in,
    input  wire logic [7:0]  main_sel_in,
    input  wire logic [3:0]  sec_sel_in,
    input  wire logic [19:0] addr_in,
    input  wire logic [15:0] data_in,
    // data back to host
    output logic [15:0]      data_out
);
    logic [15:0] mem [logic [31:0]];
    logic [11:0] sel;
    logic [19:0] pa;
    logic [7:0]  d;
    logic [2:0]  step = 3'd0;
    logic        id_mode = 1'b0, prog_next = 1'b0, bypass = 1'b0, byp_exit = 1'b0;
    logic        erasing = 1'b0, susp = 1'b0, rd_seen_q = 1'b0;
    logic [15:0] val_q = 16'h0000, last_q = 16'h0000;
    int          cnt = 0, wr_cnt = 0;
    assign sel = {sec_sel_in, main_sel_in};
    task automatic erase(input logic [11:0] m);
        foreach (mem[k]) begin
            if ((k[31:20] & m & ~PROT_MASK) != 12'h000) mem[k] = 16'hffff;
        end
        erasing = 1'b1;
        cnt = 0;
    endtask : erase
    function automatic logic [15:0] rd_val();
        if (id_mode && main_sel_in != 8'h00 && addr_in[11:0] == 12'h002) return {8'h00, ID_CODE};
        if (id_mode && addr_in[11:0] == 12'h004) return {15'h0, (sel & PROT_MASK) != 12'h000};
        return mem.exists({sel, addr_in}) ? mem[{sel, addr_in}] : 16'hffff;
    endfunction : rd_val
    always @(negedge wr_n_in) pa = addr_in;
    always @(posedge wr_n_in) begin
        d = data_in[7:0];
        if (sel != 12'h000) begin
            wr_cnt++;
            if (prog_next) begin
                if ((sel & PROT_MASK) == 12'h000) mem[{sel, pa}] = data_in;
                prog_next = 1'b0;
            end else if (bypass) begin
                prog_next = (d == 8'ha0);
                bypass = !(byp_exit && d == 8'h00);
                byp_exit = (d == 8'h90);
            end else if (d == 8'hf0) begin
                id_mode = 1'b0;
                step = 3'd0;
            end else if (step == 3'd0) begin
                step = (d == 8'haa && pa[11:0] == 12'haaa) ? 3'd1 : 3'd0;
                if (d == 8'hb0 && !pa[0] && erasing && !susp) susp = 1'b1;
                else if (d == 8'h30 && !pa[0] && susp) susp = 1'b0;
                else if (d == 8'h30 && erasing) erase(sel);
            end else if (step == 3'd2) begin
                id_mode = (pa[11:0] == 12'haaa && d == 8'h90);
                prog_next = (pa[11:0] == 12'haaa && d == 8'ha0);
                bypass = (pa[11:0] == 12'haaa && d == 8'h20);
                step = (pa[11:0] == 12'haaa && d == 8'h80) ? 3'd3 : 3'd0;
            end else if (step == 3'd5) begin
                if (d == 8'h30) erase(sel);
                if (d == 8'h10 && pa[11:0] == 12'haaa) erase(main_sel_in != 8'h00 ? 12'h0ff : 12'hf00);
                step = 3'd0;
            end else begin
                step = (d == (step == 3'd3 ? 8'haa : 8'h55) &&
                        pa[11:0] == (step == 3'd3 ? 12'haaa : 12'h554)) ? step + 3'd1 : 3'd0;
            end
        end
    end
    always @(posedge clk_in) begin
        if (erasing && !susp) cnt++;
        if (cnt >= ERASE_CYC) erasing = 1'b0;
        last_q <= data_out;
        rd_seen_q <= !rd_n_in && sel != 12'h000;
        if (!rd_n_in && sel != 12'h000) val_q <= rd_val();
    end
    // released bus shows a changing pattern, never the last value
    assign data_out = (sel != 12'h000 && (rd_seen_q || !rd_n_in)) ? val_q : ~last_q;
endmodule : fcs_dev_model

// File: sim/fcs_host_tb_top.sv
// self-checking bench for the flash command sequencer host controller
`timescale 1ns/1ps
`include "fcs_consts.svh"
module fcs_host_tb_top;
    import fcs_pkg::*;
    localparam logic [7:0]  ID   = 8'h5c; // arbitrary identifier value
    localparam logic [11:0] PROT = 12'h024;
    logic        ref_clk_in = 1'b0, rst_n_in = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, pready, pslverr, power_good = 1'b1, wr_n, rd_n, doe_n;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [15:0] dev_din, dev_dout;
    logic [7:0]  msel;
    logic [3:0]  ssel;
    logic [19:0] daddr;
    int          num_errors = 0, tests_run = 0, cycles = 0;
    always #10 ref_clk_in = ~ref_clk_in;
    fcs_host uut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .power_good_in(power_good), .dev_data_in(dev_din), .dev_wr_n_out(wr_n),
        .dev_rd_n_out(rd_n), .main_sector_select_out(msel), .secondary_sector_select_out(ssel),
        .dev_addr_out(daddr), .dev_data_out(dev_dout), .dev_data_oe_n_out(doe_n));
    fcs_dev_model #(.ID_CODE(ID), .PROT_MASK(PROT), .ERASE_CYC(5000)) dev (.clk_in(ref_clk_in),
        .wr_n_in(wr_n), .rd_n_in(rd_n), .main_sel_in(msel), .sec_sel_in(ssel),
        .addr_in(daddr), .data_in(dev_dout), .data_out(dev_din));
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge ref_clk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk_in);
        penable <= 1'b1;
        do @(posedge ref_clk_in); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic run_op(input fcs_op_t op, input logic [19:0] a, input logic [15:0] d,
                          input logic [11:0] s, output logic [15:0] rd);
        logic [31:0] r;
        logic        e;
        int          n;
        apb(1'b1, `FCS_REG_ADDR, {12'h0, a}, r, e);
        apb(1'b1, `FCS_REG_DATA, {16'h0, d}, r, e);
        apb(1'b1, `FCS_REG_SEL, {20'h0, s}, r, e);
        apb(1'b1, `FCS_REG_CTRL, {24'h0, op, 4'h1}, r, e);
        n = 0;
        do begin
            apb(1'b0, `FCS_REG_STATUS, 32'h0, r, e);
            n++;
        end while (r[0] !== 1'b0 && n < 200);
        check("busy after op", 32'h0, {31'h0, r[0]});
        apb(1'b0, `FCS_REG_RDATA, 32'h0, r, e);
        rd = r[15:0];
    endtask : run_op
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 90000) begin
            num_errors++;
            summarize();
        end
    end
    initial begin
        logic [15:0] rd, d;
        logic [19:0] a;
        logic [11:0] s;
        logic [31:0] r;
        logic        e;
        int          n;
        void'($urandom(32'h445b));
        repeat (8) @(posedge ref_clk_in);
        check("strobe in reset", 32'h1, {31'h0, wr_n});
        check("selects in reset", 32'h0, {20'h0, ssel, msel});
        check("data enable in reset", 32'h1, {31'h0, doe_n});
        rst_n_in <= 1'b1;
        run_op(FCS_OP_READ, 20'h01000, 16'h0, 12'h001, rd);
        check("blank read", 32'hffff, {16'h0, rd});
        for (int i = 0; i < 8; i++) begin
            a = 20'($urandom) & 20'hffff8;
            d = 16'($urandom);
            s = 12'h001 << $urandom_range(11, 0);
            s = ((s & PROT) != 12'h000) ? 12'h001 : s;
            run_op(FCS_OP_PROG, a, d, s, rd);
            run_op(FCS_OP_READ, a, 16'h0, s, rd);
            check("program readback", {16'h0, d}, {16'h0, rd});
        end
        run_op(FCS_OP_ID, 20'h0, 16'h0, 12'h004, rd);
        check("identifier", {24'h0, ID}, {24'h0, rd[7:0]});
        run_op(FCS_OP_RESET, 20'h0, 16'h0, 12'h004, rd);
        run_op(FCS_OP_READ, 20'h30002, 16'h0, 12'h004, rd);
        check("read after reset", 32'hffff, {16'h0, rd});
        run_op(FCS_OP_ID, 20'h0, 16'h0, 12'h100, rd);
        check("no secondary identifier", 32'hffff, {16'h0, rd});
        for (int i = 0; i < 12; i++) begin
            run_op(FCS_OP_PROT, 20'h0, 16'h0, 12'h001 << i, rd);
            check("protection", {31'h0, PROT[i]}, {24'h0, rd[7:0]});
            run_op(FCS_OP_RESET, 20'h0, 16'h0, 12'h001, rd);
        end
        run_op(FCS_OP_PROG, 20'h40010, 16'h1234, 12'h002, rd);
        run_op(FCS_OP_SECT, 20'h40000, 16'h0, 12'h002, rd);
        run_op(FCS_OP_SECT_ADD, 20'h50000, 16'h0, 12'h008, rd);
        apb(1'b0, `FCS_REG_STATUS, 32'h0, r, e);
        check("extension late", 32'h0, {31'h0, r[2]});
        check("erase window open", 32'h1, {31'h0, r[3]});
        run_op(FCS_OP_SUSP, 20'h40000, 16'h0, 12'h002, rd);
        check("suspended", 32'h1, {31'h0, dev.susp});
        run_op(FCS_OP_PROG, 20'h60020, 16'h5aa5, 12'h010, rd);
        run_op(FCS_OP_READ, 20'h60020, 16'h0, 12'h010, rd);
        check("program while suspended", 32'h5aa5, {16'h0, rd});
        run_op(FCS_OP_RESUME, 20'h40000, 16'h0, 12'h002, rd);
        check("resumed", 32'h0, {31'h0, dev.susp});
        repeat (5100) @(posedge ref_clk_in);
        run_op(FCS_OP_SECT_ADD, 20'h50000, 16'h0, 12'h008, rd);
        apb(1'b0, `FCS_REG_STATUS, 32'h0, r, e);
        check("extension late flagged", 32'h1, {31'h0, r[2]});
        run_op(FCS_OP_READ, 20'h40010, 16'h0, 12'h002, rd);
        check("sector erased", 32'hffff, {16'h0, rd});
        run_op(FCS_OP_SUSP, 20'h40000, 16'h0, 12'h002, rd);
        check("idle suspend ignored", 32'h0, {31'h0, dev.susp});
        run_op(FCS_OP_PROG, 20'h70100, 16'h0f0f, 12'h080, rd);
        run_op(FCS_OP_BULK, 20'h0, 16'h0, 12'h080, rd);
        run_op(FCS_OP_READ, 20'h70100, 16'h0, 12'h080, rd);
        check("bulk erased", 32'hffff, {16'h0, rd});
        run_op(FCS_OP_BYP_ON, 20'h0, 16'h0, 12'h200, rd);
        run_op(FCS_OP_BYP_PROG, 20'h12346, 16'hc3c3, 12'h200, rd);
        run_op(FCS_OP_BYP_OFF, 20'h0, 16'h0, 12'h200, rd);
        check("bypass left", 32'h0, {31'h0, dev.bypass});
        run_op(FCS_OP_READ, 20'h12346, 16'h0, 12'h200, rd);
        check("bypass program", 32'hc3c3, {16'h0, rd});
        power_good <= 1'b0;
        n = dev.wr_cnt;
        run_op(FCS_OP_PROG, 20'h22220, 16'h1111, 12'h001, rd);
        apb(1'b0, `FCS_REG_STATUS, 32'h0, r, e);
        check("power flag", 32'h0, {31'h0, r[`FCS_ST_PWR_BIT]});
        check("writes while low supply", n, dev.wr_cnt);
        power_good <= 1'b1;
        apb(1'b1, 12'h020, 32'h0, r, e);
        check("unmapped error", 32'h1, {31'h0, e});
        summarize();
    end
endmodule : fcs_host_tb_top
